/* File: rtl/asp_pkg.sv */
// axis parameter bank package: numbers, reset values, codes, carrier structs.
// assumes at most one host command per cycle.
package asp_pkg;

	// axis count and clock timing
	localparam int NUM_AXES_DEF          = 6;
	localparam int CLK_PERIOD_NS         = 5;
	localparam int MS_NS                 = 1000000;
	localparam int MS_CYCLES_DEF         = MS_NS / CLK_PERIOD_NS;
	localparam int STANDSTILL_CYCLES_DEF = 2 ** 20;
	localparam int STANDBY_UNIT_MS       = 10;

	// axis parameter numbers
	localparam logic [7:0] PN_BOOST      = 8'hC8;
	localparam logic [7:0] PN_FREEWHEEL  = 8'hCC;
	localparam logic [7:0] PN_LOAD       = 8'hCE;
	localparam logic [7:0] PN_STALL_ERR  = 8'hCF;
	localparam logic [7:0] PN_DRV_STATUS = 8'hD0;
	localparam logic [7:0] PN_GROUP      = 8'hD5;
	localparam logic [7:0] PN_STANDBY    = 8'hD6;

	// values after reset and write limits
	localparam logic [7:0]  BOOST_RST     = 8'h00;
	localparam logic [15:0] FREEWHEEL_RST = 16'h0000;
	localparam logic [7:0]  GROUP_RST     = 8'h00;
	localparam logic [15:0] STANDBY_RST   = 16'h00C8;
	localparam logic [31:0] BYTE_MAX      = 32'h000000FF;
	localparam logic [31:0] DELAY_MAX     = 32'h0000FFFF;

	// global banks and bank 0 auto-store window
	localparam logic [7:0] BANK_CONFIG = 8'h00;
	localparam logic [7:0] BANK_UNUSED = 8'h01;
	localparam logic [7:0] BANK_USER   = 8'h02;
	localparam logic [7:0] BANK_IRQ    = 8'h03;
	localparam logic [7:0] AUTO_LO     = 8'h40;
	localparam logic [7:0] AUTO_HI     = 8'h7F;

	// store layout {area, index}; area 1 is axis words
	localparam int         NVM_AW        = 10;
	localparam logic [1:0] NVM_AXIS_AREA = 2'h1;

	// driver status bit positions
	localparam int DS_STALL      = 0;
	localparam int DS_OT_SHUT    = 1;
	localparam int DS_OT_WARN    = 2;
	localparam int DS_SHORT_A    = 3;
	localparam int DS_SHORT_B    = 4;
	localparam int DS_OPEN_A     = 5;
	localparam int DS_OPEN_B     = 6;
	localparam int DS_STANDSTILL = 7;

	typedef enum logic [3:0] {
		OP_SET_AXIS        = 4'h0,
		OP_GET_AXIS        = 4'h1,
		OP_STORE_AXIS      = 4'h2,
		OP_RESTORE_AXIS    = 4'h3,
		OP_SET_GLOBAL      = 4'h4,
		OP_GET_GLOBAL      = 4'h5,
		OP_ACC_TO_GLOBAL   = 4'h6,
		OP_STORE_GLOBAL    = 4'h7,
		OP_RESTORE_GLOBAL  = 4'h8,
		OP_ROTATE_LEFT     = 4'h9,
		OP_ROTATE_RIGHT    = 4'hA,
		OP_MOTOR_STOP      = 4'hB,
		OP_MOVE_TO_POS     = 4'hC,
		OP_REFERENCE_SRCH  = 4'hD
	} asp_op_t;

	typedef enum logic [2:0] {
		ST_OK        = 3'h0,
		ST_BAD_PARAM = 3'h1,
		ST_BAD_BANK  = 3'h2,
		ST_READ_ONLY = 3'h3,
		ST_BAD_VALUE = 3'h4,
		ST_BAD_AXIS  = 3'h5,
		ST_BAD_OP    = 3'h6
	} asp_status_t;

	typedef struct packed {
		asp_op_t     op;
		logic [7:0]  bank;
		logic [7:0]  index;
		logic [2:0]  axis;
		logic [31:0] value;
	} asp_cmd_t;

	typedef struct packed {
		asp_status_t status;
		logic [31:0] value;
	} asp_rsp_t;

	typedef struct packed {
		logic       stall;
		logic       ot_shutdown;
		logic       ot_warning;
		logic       short_a;
		logic       short_b;
		logic       shut_down;
		logic [1:0] chop;
		logic [1:0] polarity;
	} asp_drv_t;

endpackage

/* File: rtl/asp_param_nvm.sv */
// persistent parameter image, one write and one read port
// assumes contents survive rst_n, like a non-volatile store
`timescale 1ns/100ps
module asp_param_nvm
	import asp_pkg::*;
#(
	parameter int AW = NVM_AW
) (
	// clock
	input  wire logic          clk,
	// write port
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] addr,
	input  wire logic [31:0]   wr_data,
	// read port
	output logic [31:0]        rd_data
);

	logic [31:0] mem [2**AW];

	// stored words survive reset on purpose
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	// read shares the address with the write
	assign rd_data = mem[addr];

endmodule // asp_param_nvm

/* File: rtl/asp_axis_timer.sv */
// per-axis timers: standstill, freewheel, standby, open load
// assumes ms_tick pulses once per millisecond
`timescale 1ns/100ps
module asp_axis_timer
	import asp_pkg::*;
#(
	parameter int STANDSTILL_CYCLES = STANDSTILL_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// motion inputs
	input  wire logic        ms_tick,
	input  wire logic        step_pulse,
	input  wire logic        vel_zero,
	// delay settings
	input  wire logic [15:0] freewheel_ms,
	input  wire logic [15:0] standby_10ms,
	// chopper activity per coil
	input  wire logic [1:0]  chop,
	input  wire logic [1:0]  polarity,
	// results
	output logic             standstill,
	output logic             power_cut,
	output logic             standby,
	output logic [1:0]       open_load
);

	localparam int                SW     = $clog2(STANDSTILL_CYCLES + 1);
	localparam logic [SW-1:0]     SS_LIM = SW'(STANDSTILL_CYCLES);
	localparam logic [19:0]       MS_SAT = 20'hFFFFF;

	logic [SW-1:0] still_q;
	logic [19:0]   ms_q;
	logic [19:0]   standby_lim;
	logic [1:0]    flip;
	logic [1:0]    seen_q;
	logic [1:0]    pol_q;

	// standby limit in ms: setting times ten
	assign standby_lim = 20'({standby_10ms, 3'h0}) + 20'({standby_10ms, 1'h0});
	assign flip        = polarity ^ pol_q;

	// cycles since a step, ms since velocity zero; both saturate
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			still_q <= '0;
			ms_q    <= '0;
		end else begin
			still_q <= step_pulse ? '0 : ((still_q == SS_LIM) ? still_q : still_q + 1'b1);
			ms_q    <= !vel_zero ? '0 : ((ms_tick && ms_q != MS_SAT) ? ms_q + 1'b1 : ms_q);
		end
	end

	// registered flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			standstill <= 1'b0;
			power_cut  <= 1'b0;
			standby    <= 1'b0;
		end else begin
			standstill <= (still_q == SS_LIM);
			power_cut  <= vel_zero && freewheel_ms != 16'h0000
				&& ms_q >= 20'(freewheel_ms);
			standby    <= vel_zero && ms_q >= standby_lim;
		end
	end

	// open load: polarity period ended with no chop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_q    <= 2'h0;
			pol_q     <= 2'h0;
			open_load <= 2'h0;
		end else begin
			pol_q     <= polarity;
			seen_q    <= ~flip & (seen_q | chop);
			open_load <= (flip & ~(seen_q | chop)) | (~flip & open_load);
		end
	end

endmodule // asp_axis_timer

/* File: rtl/asp_axis_param_bank.sv */
// axis parameter bank with global banks and persistent store
// assumes one host command per cycle; reply one cycle later
// Function
// - boost current while ramping; zero boost uses run current
// - power cut once nonzero freewheel ms pass after velocity zero; zero never cuts
// - read-only load value 0..1023 from stall measurement
// - stall flag sticks until read or motion command
// - status byte; bit 0: stall threshold reached
// - bit 1: overtemperature shutdown
// - bit 2: overtemperature warning
// - bits 3, 4: coil A, B shorted to ground, driver shut down
// - bits 5, 6: open load, no chop in last polarity period
// - bit 7: no step pulse in the last 2^20 cycles
// - motion commands also reach axes with the same nonzero group
// - group index zero, the default, disables sharing
// - standby current after delay in 10 ms units, default 2000 ms
// - global banks: 0 config, 1 unused, 2 user, 3 interrupt
// - bank 0 numbers 64 to 127 persist on every write
// - storable parameters saved and restored by explicit commands
`timescale 1ns/100ps
module asp_axis_param_bank
	import asp_pkg::*;
#(
	parameter int NUM_AXES          = NUM_AXES_DEF,
	parameter int MS_CYCLES         = MS_CYCLES_DEF,
	parameter int STANDSTILL_CYCLES = STANDSTILL_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// parameter command port
	input  wire logic                     cmd_valid,
	input  wire asp_cmd_t                 cmd,
	input  wire logic [31:0]              acc_value,
	// reply port
	output logic                          rsp_valid,
	output asp_rsp_t                      rsp,
	// motion dispatch
	output logic [NUM_AXES-1:0]           motion_go,
	output asp_op_t                       motion_op,
	output logic [31:0]                   motion_value,
	// driver and motion state per axis
	input  wire asp_drv_t [NUM_AXES-1:0]  drv,
	input  wire logic [NUM_AXES-1:0][9:0] load_meas,
	input  wire logic [NUM_AXES-1:0]      step_pulse,
	input  wire logic [NUM_AXES-1:0]      vel_zero,
	input  wire logic [NUM_AXES-1:0]      ramp_active,
	input  wire logic [NUM_AXES-1:0][7:0] run_current,
	input  wire logic [NUM_AXES-1:0][7:0] standby_current,
	// current control per axis
	output logic [NUM_AXES-1:0][7:0]      coil_current,
	output logic [NUM_AXES-1:0]           power_cut,
	output logic [NUM_AXES-1:0]           standby_on
);

	localparam int MSW = $clog2(MS_CYCLES);
	localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);

	// axis write check; also tells known numbers
	function automatic asp_status_t axis_set_check(input logic [7:0] idx,
		input logic [31:0] v);
		asp_status_t s;
		case (idx)
			PN_BOOST:      s = (v > BYTE_MAX) ? ST_BAD_VALUE : ST_OK;
			PN_GROUP:      s = (v > BYTE_MAX) ? ST_BAD_VALUE : ST_OK;
			PN_FREEWHEEL:  s = (v > DELAY_MAX) ? ST_BAD_VALUE : ST_OK;
			PN_STANDBY:    s = (v == 32'h0 || v > DELAY_MAX) ? ST_BAD_VALUE : ST_OK;
			PN_LOAD:       s = ST_READ_ONLY;
			PN_STALL_ERR:  s = ST_READ_ONLY;
			PN_DRV_STATUS: s = ST_READ_ONLY;
			default:       s = ST_BAD_PARAM;
		endcase
		return s;
	endfunction

	// per-axis registers
	logic [7:0]  boost_q     [NUM_AXES];
	logic [15:0] freewheel_q [NUM_AXES];
	logic [7:0]  group_q     [NUM_AXES];
	logic [15:0] standby_q   [NUM_AXES];
	logic [9:0]  load_q      [NUM_AXES];
	logic        stall_err_q [NUM_AXES];
	logic [7:0]  status_q    [NUM_AXES];

	// global banks, one word per {bank, number}
	logic [31:0] glob_mem [1024];

	logic [MSW-1:0]      ms_cnt_q;
	logic                ms_tick;
	logic [2:0]          ax;
	logic [2:0]          axs;
	logic                axis_ok;
	logic                is_set_axis;
	logic                is_get_axis;
	logic                is_store_axis;
	logic                is_restore_axis;
	logic                is_set_global;
	logic                is_get_global;
	logic                is_acc_global;
	logic                is_store_global;
	logic                is_restore_global;
	logic                is_motion;
	logic                is_axis_op;
	logic                is_global_op;
	logic                bank_ok;
	logic                auto_store;
	logic                stor_ok;
	logic                stor_sel;
	logic                cmd_ok;
	asp_status_t         st;
	logic [9:0]          gaddr;
	logic [NVM_AW-1:0]   nvm_addr;
	logic                nvm_wr;
	logic [31:0]         nvm_wdata;
	logic [31:0]         nvm_rdata;
	logic [31:0]         glob_rdata;
	logic                glob_wr;
	logic [31:0]         glob_wdata;
	logic                ax_wr;
	logic [31:0]         ax_wdata;
	logic [31:0]         ax_rdata;
	logic [7:0]          grp_sel;
	logic [NUM_AXES-1:0] go_d;
	asp_rsp_t            rsp_d;

	// millisecond tick shared by all axes
	assign ms_tick = (ms_cnt_q == MS_LAST);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_q <= '0;
		end else begin
			ms_cnt_q <= ms_tick ? '0 : ms_cnt_q + 1'b1;
		end
	end

	// command decode
	assign ax                = cmd.axis;
	assign axis_ok           = (int'(ax) < NUM_AXES);
	assign axs               = axis_ok ? ax : 3'h0;
	assign is_set_axis       = cmd_valid && cmd.op == OP_SET_AXIS;
	assign is_get_axis       = cmd_valid && cmd.op == OP_GET_AXIS;
	assign is_store_axis     = cmd_valid && cmd.op == OP_STORE_AXIS;
	assign is_restore_axis   = cmd_valid && cmd.op == OP_RESTORE_AXIS;
	assign is_set_global     = cmd_valid && cmd.op == OP_SET_GLOBAL;
	assign is_get_global     = cmd_valid && cmd.op == OP_GET_GLOBAL;
	assign is_acc_global     = cmd_valid && cmd.op == OP_ACC_TO_GLOBAL;
	assign is_store_global   = cmd_valid && cmd.op == OP_STORE_GLOBAL;
	assign is_restore_global = cmd_valid && cmd.op == OP_RESTORE_GLOBAL;
	assign is_motion         = cmd_valid && cmd.op inside {OP_ROTATE_LEFT, OP_ROTATE_RIGHT,
		OP_MOTOR_STOP, OP_MOVE_TO_POS, OP_REFERENCE_SRCH};
	assign is_axis_op        = is_set_axis | is_get_axis | is_store_axis | is_restore_axis;
	assign is_global_op      = is_set_global | is_get_global | is_acc_global
		| is_store_global | is_restore_global;

	// bank 1 holds nothing and is refused
	assign bank_ok    = cmd.bank == BANK_CONFIG || cmd.bank == BANK_USER
		|| cmd.bank == BANK_IRQ;
	assign gaddr      = {cmd.bank[1:0], cmd.index};
	assign auto_store = cmd.bank == BANK_CONFIG && cmd.index >= AUTO_LO
		&& cmd.index <= AUTO_HI;
	assign stor_ok    = cmd.index == PN_FREEWHEEL || cmd.index == PN_STANDBY;
	assign stor_sel   = cmd.index == PN_STANDBY;

	// command status; anything but ok changes no state except motion_op and motion_value
	always_comb begin
		st = ST_OK;
		if (!(is_axis_op | is_global_op | is_motion)) begin
			st = ST_BAD_OP;
		end else if ((is_axis_op | is_motion) && !axis_ok) begin
			st = ST_BAD_AXIS;
		end else if (is_set_axis) begin
			st = axis_set_check(cmd.index, cmd.value);
		end else if (is_get_axis) begin
			st = (axis_set_check(cmd.index, 32'h0) == ST_BAD_PARAM) ? ST_BAD_PARAM : ST_OK;
		end else if (is_store_axis | is_restore_axis) begin
			st = stor_ok ? ST_OK : ST_BAD_PARAM;
		end else if (is_global_op) begin
			st = bank_ok ? ST_OK : ST_BAD_BANK;
		end
	end
	assign cmd_ok = cmd_valid && st == ST_OK;

	// store path: explicit store and restore, bank 0 auto-store
	assign nvm_addr  = (is_store_axis | is_restore_axis)
		? {NVM_AXIS_AREA, 4'h0, axs, stor_sel} : gaddr;
	assign nvm_wr    = cmd_ok && (is_store_axis | is_store_global
		| ((is_set_global | is_acc_global) && auto_store));
	assign nvm_wdata = is_store_axis
		? (stor_sel ? {16'h0, standby_q[axs]} : {16'h0, freewheel_q[axs]})
		: (is_store_global ? glob_rdata : glob_wdata);

	asp_param_nvm #(
		.AW      (NVM_AW)
	) u_nvm (
		.clk     (clk),
		.wr_en   (nvm_wr),
		.addr    (nvm_addr),
		.wr_data (nvm_wdata),
		.rd_data (nvm_rdata)
	);

	// global bank write: set, accumulator copy, or restore
	assign glob_wr    = cmd_ok && (is_set_global | is_acc_global | is_restore_global);
	assign glob_wdata = is_set_global ? cmd.value : (is_acc_global ? acc_value : nvm_rdata);
	assign glob_rdata = glob_mem[gaddr];
	always_ff @(posedge clk) begin
		if (glob_wr) begin
			glob_mem[gaddr] <= glob_wdata;
		end
	end

	// axis write source
	assign ax_wr    = cmd_ok && (is_set_axis | is_restore_axis);
	assign ax_wdata = is_restore_axis ? nvm_rdata : cmd.value;
	assign grp_sel  = group_q[axs];

	// axis read mux
	always_comb begin
		case (cmd.index)
			PN_BOOST:      ax_rdata = {24'h0, boost_q[axs]};
			PN_FREEWHEEL:  ax_rdata = {16'h0, freewheel_q[axs]};
			PN_LOAD:       ax_rdata = {22'h0, load_q[axs]};
			PN_STALL_ERR:  ax_rdata = {31'h0, stall_err_q[axs]};
			PN_DRV_STATUS: ax_rdata = {24'h0, status_q[axs]};
			PN_GROUP:      ax_rdata = {24'h0, group_q[axs]};
			PN_STANDBY:    ax_rdata = {16'h0, standby_q[axs]};
			default:       ax_rdata = 32'h0;
		endcase
	end

	// reply content
	always_comb begin
		rsp_d.status = st;
		rsp_d.value  = 32'h0;
		if (cmd_ok && is_get_axis) begin
			rsp_d.value = ax_rdata;
		end else if (cmd_ok && is_get_global) begin
			rsp_d.value = glob_rdata;
		end
	end

	// reply and dispatch registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid    <= 1'b0;
			rsp          <= '{status: ST_OK, value: 32'h0};
			motion_go    <= '0;
			motion_op    <= OP_MOTOR_STOP;
			motion_value <= 32'h0;
		end else begin
			rsp_valid    <= cmd_valid;
			rsp          <= rsp_d;
			motion_go    <= go_d;
			motion_op    <= is_motion ? cmd.op : motion_op;
			motion_value <= is_motion ? cmd.value : motion_value;
		end
	end

	// per-axis logic
	for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
		logic       hit;
		logic       wr_a;
		logic       stall_clr;
		logic       stand_a;
		logic       cut_a;
		logic       sby_a;
		logic [1:0] open_a;
		logic [7:0] cur_d;

		assign hit  = (ax == 3'(a));
		assign wr_a = ax_wr && hit;

		// target axis, plus axes in its nonzero group
		assign go_d[a] = cmd_ok && is_motion && (hit
			|| (group_q[a] != 8'h00 && group_q[a] == grp_sel));

		// writable settings
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				boost_q[a]     <= BOOST_RST;
				freewheel_q[a] <= FREEWHEEL_RST;
				group_q[a]     <= GROUP_RST;
				standby_q[a]   <= STANDBY_RST;
			end else if (wr_a) begin
				if (cmd.index == PN_BOOST) boost_q[a] <= ax_wdata[7:0];
				if (cmd.index == PN_FREEWHEEL) freewheel_q[a] <= ax_wdata[15:0];
				if (cmd.index == PN_GROUP) group_q[a] <= ax_wdata[7:0];
				if (cmd.index == PN_STANDBY) standby_q[a] <= ax_wdata[15:0];
			end
		end

		// read of the flag or a motion command clears it; a new stall wins
		assign stall_clr = (cmd_ok && is_get_axis && hit && cmd.index == PN_STALL_ERR)
			|| go_d[a];

		// status capture
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				load_q[a]      <= 10'h000;
				stall_err_q[a] <= 1'b0;
				status_q[a]    <= 8'h00;
			end else begin
				load_q[a]      <= load_meas[a];
				stall_err_q[a] <= drv[a].stall || (stall_err_q[a] && !stall_clr);
				status_q[a][DS_STALL]      <= drv[a].stall;
				status_q[a][DS_OT_SHUT]    <= drv[a].ot_shutdown;
				status_q[a][DS_OT_WARN]    <= drv[a].ot_warning;
				status_q[a][DS_SHORT_A]    <= drv[a].short_a && drv[a].shut_down;
				status_q[a][DS_SHORT_B]    <= drv[a].short_b && drv[a].shut_down;
				status_q[a][DS_OPEN_A]     <= open_a[0];
				status_q[a][DS_OPEN_B]     <= open_a[1];
				status_q[a][DS_STANDSTILL] <= stand_a;
			end
		end

		asp_axis_timer #(
			.STANDSTILL_CYCLES (STANDSTILL_CYCLES)
		) u_timer (
			.clk               (clk),
			.rst_n             (rst_n),
			.ms_tick           (ms_tick),
			.step_pulse        (step_pulse[a]),
			.vel_zero          (vel_zero[a]),
			.freewheel_ms      (freewheel_q[a]),
			.standby_10ms      (standby_q[a]),
			.chop              (drv[a].chop),
			.polarity          (drv[a].polarity),
			.standstill        (stand_a),
			.power_cut         (cut_a),
			.standby           (sby_a),
			.open_load         (open_a)
		);

		// current select: cut, standby, boost while ramping, else run
		assign cur_d = cut_a ? 8'h00
			: (sby_a ? standby_current[a]
			: ((ramp_active[a] && boost_q[a] != 8'h00) ? boost_q[a] : run_current[a]));

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				coil_current[a] <= 8'h00;
				power_cut[a]    <= 1'b0;
				standby_on[a]   <= 1'b0;
			end else begin
				coil_current[a] <= cur_d;
				power_cut[a]    <= cut_a;
				standby_on[a]   <= sby_a;
			end
		end
	end

endmodule // asp_axis_param_bank

/* File: bench/asp_axis_param_bank_properties.sv */
// assertions on reply, status, dispatch and current ports
// assumes flag and power tests on axis 0
`timescale 1ns/100ps
module asp_axis_param_bank_properties
	import asp_pkg::*;
#(
	parameter int NUM_AXES = NUM_AXES_DEF
) (
	// clock and reset
	input wire logic                     clk,
	input wire logic                     rst_n,
	// command and reply
	input wire logic                     cmd_valid,
	input wire asp_cmd_t                 cmd,
	input wire logic                     rsp_valid,
	input wire asp_rsp_t                 rsp,
	// dispatch, drive and current
	input wire logic [NUM_AXES-1:0]      motion_go,
	input wire asp_op_t                  motion_op,
	input wire asp_drv_t [NUM_AXES-1:0]  drv,
	input wire logic [NUM_AXES-1:0]      vel_zero,
	input wire logic [NUM_AXES-1:0][7:0] coil_current,
	input wire logic [NUM_AXES-1:0]      power_cut
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// axis 0 read; flag read with no stall
	sequence s_get(logic [7:0] pn);
		cmd_valid && cmd.op == OP_GET_AXIS && cmd.index == pn && cmd.axis == 3'h0;
	endsequence
	sequence s_calm;
		s_get(PN_STALL_ERR) ##0 !drv[0].stall;
	endsequence
	// properties
	property p_ro;
		cmd_valid && cmd.op == OP_SET_AXIS && cmd.index == PN_LOAD && cmd.axis == 3'h0
			|=> rsp.status == ST_READ_ONLY;
	endproperty
	property p_stall;
		drv[0].stall ##1 !cmd_valid ##1 s_get(PN_STALL_ERR) |=> rsp.value == 32'h1;
	endproperty
	property p_clear;
		s_calm ##1 (!cmd_valid && !drv[0].stall) ##1 s_calm |=> rsp.value == 32'h0;
	endproperty
	property p_ot;
		drv[0].ot_shutdown [*2] ##0 s_get(PN_DRV_STATUS) |=> rsp.value[DS_OT_SHUT];
	endproperty
	property p_go;
		cmd_valid && cmd.op >= OP_ROTATE_LEFT && cmd.op <= OP_REFERENCE_SRCH && cmd.axis == 3'h0
			|=> motion_go[0] && motion_op == $past(cmd.op);
	endproperty
	property p_idle;
		!cmd_valid |=> !rsp_valid && motion_go == '0;
	endproperty
	property p_bank;
		cmd_valid && cmd.op == OP_SET_GLOBAL && cmd.bank == BANK_UNUSED |=> rsp.status == ST_BAD_BANK;
	endproperty
	property p_cut;
		power_cut[0] [*2] |=> coil_current[0] == 8'h00;
	endproperty
	property p_nocut;
		!vel_zero[0] [*3] |-> !power_cut[0];
	endproperty
	a_ro: assert property (p_ro) else $error("read-only write accepted");
	a_stall: assert property (p_stall) else $error("stall flag lost");
	a_clear: assert property (p_clear) else $error("stall flag not cleared");
	a_ot: assert property (p_ot) else $error("overtemp bit missing");
	a_go: assert property (p_go) else $error("motion not dispatched");
	a_idle: assert property (p_idle) else $error("reply without command");
	a_bank: assert property (p_bank) else $error("unused bank accepted");
	a_cut: assert property (p_cut) else $error("current while power cut");
	a_nocut: assert property (p_nocut) else $error("power cut while moving");
endmodule // asp_axis_param_bank_properties

/* File: bench/asp_host_model.sv */
// host model: one command, one reply
// assumes launch at the falling edge
`timescale 1ns/100ps
module asp_host_model
	import asp_pkg::*;
(
	// clock
	input  wire logic     clk,
	// command
	output asp_cmd_t      cmd,
	output logic          cmd_valid,
	output logic [31:0]   acc_value,
	// reply
	input  wire logic     rsp_valid,
	input  wire asp_rsp_t rsp
);
	// idle bus at start
	initial begin
		{cmd_valid, cmd, acc_value} = '0;
	end
	// hold, take reply, then scramble the idle bus
	task automatic xfer(input asp_cmd_t c, output asp_rsp_t r);
		@(negedge clk);
		cmd_valid = 1'b1;
		{cmd, acc_value} = {c, c.value};
		@(negedge clk);
		r = rsp_valid ? rsp : 'x;
		cmd_valid = 1'b0;
		{cmd, acc_value} = ~{c, c.value};
	endtask
endmodule // asp_host_model

/* File: bench/tb_asp_axis_param_bank.sv */
// self-checking bench for the per-axis parameter bank
// assumes the host model and short timing parameters
`timescale 1ns/100ps
module tb_asp_axis_param_bank;
	import asp_pkg::*;
	localparam int NA = NUM_AXES_DEF;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               cmd_valid, rsp_valid;
	asp_cmd_t           cmd;
	asp_rsp_t           rsp, r;
	asp_op_t            motion_op;
	asp_drv_t [NA-1:0]  drv;
	logic [31:0]        acc_value, motion_value, v, seed = 32'h225B;
	logic [7:0]         b;
	logic [NA-1:0]      motion_go, step_pulse, vel_zero, ramp_active, power_cut, standby_on;
	logic [NA-1:0][9:0] load_meas;
	logic [NA-1:0][7:0] run_current, standby_current, coil_current;
	logic [7:0]         pn [7] = '{PN_BOOST, PN_FREEWHEEL, PN_GROUP, PN_STANDBY, PN_LOAD,
		PN_STALL_ERR, PN_DRV_STATUS};
	logic [7:0]         grp [NA] = '{8'h03, 8'h00, 8'h03, 8'h07, 8'h00, 8'h07};
	logic [31:0]        sh [4][NA];
	int                 k, a, miscompares = 0, check_count = 0, cycles = 0;
	// design and host
	asp_axis_param_bank #(.MS_CYCLES(10), .STANDSTILL_CYCLES(16)) u_asp_axis_param_bank (.clk,
		.rst_n, .cmd_valid, .cmd, .acc_value, .rsp_valid, .rsp, .motion_go, .motion_op,
		.motion_value, .drv, .load_meas, .step_pulse, .vel_zero, .ramp_active, .run_current,
		.standby_current, .coil_current, .power_cut, .standby_on);
	asp_host_model u_asp_host_model (.clk, .cmd, .cmd_valid, .acc_value, .rsp_valid, .rsp);
	// clock
	always #2.5 clk = ~clk;
	// xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// expected axis write status
	function automatic asp_status_t exp_set(logic [7:0] ix, logic [31:0] val);
		if (ix inside {PN_LOAD, PN_STALL_ERR, PN_DRV_STATUS}) return ST_READ_ONLY;
		if (val > DELAY_MAX || (ix inside {PN_BOOST, PN_GROUP} && val > BYTE_MAX)) return ST_BAD_VALUE;
		return (ix == PN_STANDBY && val == 0) ? ST_BAD_VALUE : ST_OK;
	endfunction
	// axes reached by a motion on axis t
	function automatic logic [NA-1:0] exp_go(int t);
		for (int i = 0; i < NA; i++) begin
			exp_go[i] = i == t || (grp[t] != 0 && grp[i] == grp[t]);
		end
	endfunction
	// one command through the host
	task automatic go(asp_op_t op, logic [7:0] bk, ix, logic [2:0] ax, logic [31:0] val);
		u_asp_host_model.xfer('{op, bk, ix, ax, val}, r);
	endtask
	// compare and count
	task automatic chk(logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic print_verdict();
		if (miscompares == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// cycle ceiling
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		{drv, load_meas, step_pulse, vel_zero, ramp_active, run_current, standby_current} = '0;
		foreach (sh[i, j]) sh[i][j] = (i == 3) ? STANDBY_RST : 32'h0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		// reset values, then random writes read back
		for (int i = 0; i < 44; i++) begin
			k = i % 4;
			a = (i < 4) ? 5 : rnd() % NA;
			v = (i == 7) ? 32'h0 : rnd() & ((i % 3 == 0) ? 32'h1FFFF : 32'h1FF);
			if (i >= 4) begin
				go(OP_SET_AXIS, '0, pn[k], 3'(a), v);
				chk(r.status, exp_set(pn[k], v));
				if (exp_set(pn[k], v) == ST_OK) sh[k][a] = v;
			end
			go(OP_GET_AXIS, '0, pn[k], 3'(a), 0);
			chk(r.value, sh[k][a]);
		end
		for (k = 4; k < 7; k++) begin
			go(OP_SET_AXIS, '0, pn[k], '0, rnd());
			chk(r.status, ST_READ_ONLY);
		end
		v = rnd();
		load_meas[2] = v[9:0];
		go(OP_GET_AXIS, '0, PN_LOAD, 3'h2, 0);
		chk(r.value, {22'h0, v[9:0]});
		// sticky stall, cleared by read or motion
		for (b = 0; b < 2; b++) begin
			@(negedge clk);
			drv[0].stall = 1'b1;
			@(negedge clk);
			drv[0].stall = 1'b0;
			if (b == 1) go(OP_MOTOR_STOP, '0, '0, '0, 0);
			go(OP_GET_AXIS, '0, PN_STALL_ERR, '0, 0);
			chk(r.value, b == 0);
			go(OP_GET_AXIS, '0, PN_STALL_ERR, '0, 0);
			chk(r.value, 0);
		end
		// driver flags, standstill, then steps and open load
		for (b = 0; b < 5; b++) begin
			@(negedge clk);
			drv[0] = asp_drv_t'((10'h200 >> b) | 10'h010);
			go(OP_GET_AXIS, '0, PN_DRV_STATUS, '0, 0);
			chk(r.value, 32'h80 | (32'h1 << b));
		end
		drv[0] = asp_drv_t'(10'h003);
		step_pulse[0] = 1'b1;
		repeat (3) @(negedge clk);
		go(OP_GET_AXIS, '0, PN_DRV_STATUS, '0, 0);
		chk(r.value, 32'h60);
		step_pulse[0] = 1'b0;
		// group dispatch, every op and target
		for (a = 0; a < NA; a++) go(OP_SET_AXIS, '0, PN_GROUP, 3'(a), {24'h0, grp[a]});
		for (int i = 0; i < 5 * NA; i++) begin
			go(asp_op_t'(OP_ROTATE_LEFT + i % 5), '0, '0, 3'(i / 5), rnd());
			chk(motion_go, exp_go(i / 5));
			chk(motion_op, OP_ROTATE_LEFT + i % 5);
		end
		// banks, accumulator, store and auto-store
		for (b = 0; b < 4; b++) begin
			v = rnd();
			go(OP_SET_GLOBAL, b, 8'h20, 3'h0, v);
			chk(r.status, (b == 1) ? ST_BAD_BANK : ST_OK);
			go(OP_ACC_TO_GLOBAL, b, 8'h21, 3'h0, ~v);
			go(OP_GET_GLOBAL, b, 8'h21, 3'h0, 0);
			if (b != 1) chk(r.value, ~v);
		end
		go(OP_STORE_GLOBAL, BANK_IRQ, 8'h20, '0, 0);
		go(OP_SET_GLOBAL, BANK_IRQ, 8'h20, '0, 0);
		go(OP_SET_GLOBAL, BANK_CONFIG, AUTO_LO, '0, ~v);
		for (k = 0; k < 2; k++) begin
			b = (k == 0) ? 8'h20 : AUTO_LO;
			go(OP_RESTORE_GLOBAL, k ? BANK_CONFIG : BANK_IRQ, b, '0, 0);
			go(OP_GET_GLOBAL, k ? BANK_CONFIG : BANK_IRQ, b, '0, 0);
			chk(r.value, (k == 0) ? v : ~v);
		end
		// boost, run current at zero boost, freewheel cut
		run_current[0] = 8'h20;
		ramp_active[0] = 1'b1;
		go(OP_SET_AXIS, '0, PN_BOOST, '0, 32'h40);
		go(OP_SET_AXIS, '0, PN_FREEWHEEL, '0, 32'h2);
		chk(coil_current[0], 8'h40);
		vel_zero[0] = 1'b1;
		go(OP_SET_AXIS, '0, PN_BOOST, '0, 0);
		@(negedge clk);
		chk(coil_current[0], 8'h20);
		chk(power_cut[0], 1'b0);
		repeat (40) @(negedge clk);
		chk(power_cut[0], 1'b1);
		print_verdict();
	end
endmodule // tb_asp_axis_param_bank
bind asp_axis_param_bank asp_axis_param_bank_properties #(.NUM_AXES(NUM_AXES)) u_props (.clk,
	.rst_n, .cmd_valid, .cmd, .rsp_valid, .rsp, .motion_go, .motion_op, .drv, .vel_zero,
	.coil_current, .power_cut);
